// ==== core/pcm_pkg.sv ====
package pcm_pkg;

    // ------------------------------------------------------------
    // Sample and slot geometry
    // ------------------------------------------------------------
    localparam int         SAMPLE_BITS   = 8;
    localparam logic [2:0] SLOT_LAST     = 3'h7;
    localparam logic [7:0] QUIET_CODE    = 8'h7F;   // Negative zero, mu-law

    // ------------------------------------------------------------
    // Port modes and power-up defaults
    // ------------------------------------------------------------
    typedef enum logic {
        MODE_STROBED,
        MODE_BACKPLANE
    } port_mode_t;

    localparam port_mode_t RESET_MODE  = MODE_STROBED;
    localparam logic       RESET_ALAW  = 1'h0;      // Zero selects mu-law

    // ------------------------------------------------------------
    // Cascade output timing, in bit clocks
    // ------------------------------------------------------------
    localparam int         CASCADE_SLOTS     = 4;
    localparam logic [5:0] CASCADE_DELAY     = 6'(CASCADE_SLOTS * SAMPLE_BITS);
    localparam logic [5:0] POS_MAX           = 6'h3F;
    localparam logic [3:0] STROBE_WIDTH      = 4'h8;
    localparam logic [3:0] FRAME_PULSE_WIDTH = 4'h1;

    // ------------------------------------------------------------
    // Link clock generation at the timing master
    // ------------------------------------------------------------
    localparam int         CLK_FREQ_KHZ   = 125000;
    localparam int         BIT_RATE_KBPS  = 2048;
    localparam int         FRAME_RATE_KHZ = 8;
    localparam logic [4:0] HALF_DIV_LAST  = 5'(CLK_FREQ_KHZ / (2 * BIT_RATE_KBPS) - 1);
    localparam logic [7:0] FRAME_LAST     = 8'(BIT_RATE_KBPS / FRAME_RATE_KHZ - 1);
    localparam logic [7:0] SLOT_END       = 8'h08;

endpackage : pcm_pkg

// ==== core/pcm_link_if.sv ====
`timescale 1ns/1ns
interface pcm_link_if;
    logic bit_clk;               // Link bit clock, made by the timing master
    logic slot_strobe_frame;     // Slot strobe or frame pulse
    logic host_data;             // Serial data towards the device
    logic dev_data;              // Serial data from the device
    logic dev_data_oe;           // Device drives dev_data while high
    logic delayed_strobe_frame;  // Cascade strobe from the device
    wire  line_level;            // Resolved shared data line

    // Shared line floats high when nobody drives it
    assign line_level = dev_data_oe ? dev_data : 1'h1;

    modport device (
        input  bit_clk,
        input  slot_strobe_frame,
        input  host_data,
        output dev_data,
        output dev_data_oe,
        output delayed_strobe_frame
    );

    modport host (
        output bit_clk,
        output slot_strobe_frame,
        output host_data,
        input  line_level,
        input  delayed_strobe_frame
    );
endinterface : pcm_link_if

// ==== core/slot_shifter.sv ====
`timescale 1ns/1ns
module slot_shifter (
    input  wire logic       link_clk_in,
    input  wire logic       rstn_in,
    input  wire logic       start_in,
    input  wire logic [7:0] tx_word_in,
    input  wire logic       data_in,
    output logic            data_out,
    output logic            data_oe_out,
    output logic [7:0]      rx_word_out,
    output logic            rx_toggle_out
);
    logic [7:0] tx_shift;
    logic [7:0] rx_shift;
    logic [2:0] bit_cnt;
    logic       active;
    wire        last_bit = (bit_cnt == pcm_pkg::SLOT_LAST);

    // ------------------------------------------------------------
    // Transmit on rising edges, MSB first
    // ------------------------------------------------------------
    always_ff @(posedge link_clk_in) begin
        if (!rstn_in) begin
            tx_shift <= pcm_pkg::QUIET_CODE;
            bit_cnt  <= 3'h0;
            active   <= 1'h0;
        end else if (start_in) begin
            tx_shift <= tx_word_in;           // see [R10]
            bit_cnt  <= 3'h0;
            active   <= 1'h1;
        end else if (active) begin
            tx_shift <= {tx_shift[6:0], 1'h0};
            bit_cnt  <= last_bit ? bit_cnt : bit_cnt + 3'h1;
            active   <= !last_bit;            // see [R12]
        end
    end

    // Output driven only inside the own slot
    assign data_out    = tx_shift[7];
    assign data_oe_out = active;              // see [R12]

    // ------------------------------------------------------------
    // Receive on falling edges inside the same slot
    // ------------------------------------------------------------
    always_ff @(negedge link_clk_in) begin
        if (!rstn_in) begin
            rx_shift      <= 8'h00;
            rx_word_out   <= 8'h00;
            rx_toggle_out <= 1'h0;
        end else if (active) begin
            rx_shift <= {rx_shift[6:0], data_in};          // see [R1]
            if (last_bit) begin
                rx_word_out   <= {rx_shift[6:0], data_in};
                rx_toggle_out <= !rx_toggle_out;
            end
        end
    end

endmodule : slot_shifter

// ==== core/pcm_device_end.sv ====
// How it works
// [R1] Receive byte sampled on falling clock inside slot
// [R2] Strobed mode: one slot for both directions
// [R3] Master drives strobe high, once per frame
// [R4] Strobed mode: 8-bit delayed strobe after strobe falls
// [R5] Backplane mode: frame pulse delayed four slots
// [R6] Fast strobed bit clock also feeds master clock
// [R7] Slow bit clock needs a 4096 kHz master clock
// [R8] Backplane clock and standard frame pulse supplied
// [R9] Runs from power-up defaults without a controller
// [R10] Transmit byte shifted out on rising clock edges
// [R11] Reset selects strobed mode, 2048 kb/s, mu-law
// [R12] Output high impedance outside own slot
`timescale 1ns/1ns
module pcm_device_end #(
    parameter bit HAS_DELAYED_OUT = 1'b1
) (
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    pcm_link_if.device      link,
    input  wire logic [7:0] tx_data_in,
    input  wire logic       tx_valid_in,
    output logic            tx_ready_out,
    output logic [7:0]      rx_data_out,
    output logic            rx_valid_out,
    input  wire logic       cfg_load_in,
    input  wire logic       cfg_backplane_in,
    input  wire logic       cfg_alaw_in,
    output logic            mode_backplane_out,
    output logic            law_alaw_out
);

    // ------------------------------------------------------------
    // Declarations, user clock domain
    // ------------------------------------------------------------
    pcm_pkg::port_mode_t port_mode;
    logic                law_alaw;
    logic [7:0]          tx_hold;
    logic                tx_req;
    logic                ack_meta;
    logic                ack_sync;
    logic                rxt_meta;
    logic                rxt_sync;
    logic                rxt_seen;
    logic [7:0]          rx_data;
    logic                rx_valid;

    // ------------------------------------------------------------
    // Declarations, link clock domain
    // ------------------------------------------------------------
    logic                lrst_meta;
    logic                lrstn;
    logic                mode_meta;
    logic                mode_link;
    logic                req_meta;
    logic                req_link;
    logic                req_seen;
    logic [7:0]          tx_next;
    logic                strobe_prev;
    logic [5:0]          slot_pos;
    logic [3:0]          dly_cnt;
    logic [7:0]          rx_word_link;
    logic                rx_toggle_link;

    // ------------------------------------------------------------
    // Decodes
    // ------------------------------------------------------------
    wire backplane_link = mode_link;
    wire strobe_rise    = link.slot_strobe_frame && !strobe_prev;
    wire strobe_fall    = !link.slot_strobe_frame && strobe_prev;
    wire req_new        = (req_link != req_seen);
    wire tx_take        = tx_valid_in && tx_ready_out;
    wire rx_new         = (rxt_sync != rxt_seen);
    wire pos_at_delay   = (slot_pos == pcm_pkg::CASCADE_DELAY - 6'h01);
    wire dly_load_strb  = !backplane_link && strobe_fall;          // see [R4]
    wire dly_load_fp    = backplane_link && pos_at_delay;          // see [R5]

    // ------------------------------------------------------------
    // Configuration, defaults hold with no controller attached
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            port_mode <= pcm_pkg::RESET_MODE;     // see [R11]
            law_alaw  <= pcm_pkg::RESET_ALAW;     // see [R11]
        end else if (cfg_load_in) begin
            port_mode <= cfg_backplane_in ? pcm_pkg::MODE_BACKPLANE : pcm_pkg::MODE_STROBED;
            law_alaw  <= cfg_alaw_in;
        end
    end

    // Status of the current configuration
    assign mode_backplane_out = (port_mode == pcm_pkg::MODE_BACKPLANE);  // see [R9]
    assign law_alaw_out       = law_alaw;

    // ------------------------------------------------------------
    // Transmit sample hand-over, user side of the toggle handshake
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            tx_hold  <= pcm_pkg::QUIET_CODE;
            tx_req   <= 1'h0;
            ack_meta <= 1'h0;
            ack_sync <= 1'h0;
        end else begin
            ack_meta <= req_seen;
            ack_sync <= ack_meta;
            if (tx_take) begin
                tx_hold <= tx_data_in;
                tx_req  <= !tx_req;
            end
        end
    end

    // Ready while no hand-over is in flight
    assign tx_ready_out = (tx_req == ack_sync);

    // ------------------------------------------------------------
    // Receive sample hand-over, user side
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            rxt_meta <= 1'h0;
            rxt_sync <= 1'h0;
            rxt_seen <= 1'h0;
            rx_data  <= 8'h00;
            rx_valid <= 1'h0;
        end else begin
            rxt_meta <= rx_toggle_link;
            rxt_sync <= rxt_meta;
            rxt_seen <= rxt_sync;
            rx_valid <= rx_new;
            if (rx_new) begin
                rx_data <= rx_word_link;   // Word is stable for most of a frame
            end
        end
    end

    // Received sample to the user
    assign rx_data_out  = rx_data;
    assign rx_valid_out = rx_valid;

    // ------------------------------------------------------------
    // Link domain reset and configuration synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge link.bit_clk) begin
        lrst_meta <= rstn_in;
        lrstn     <= lrst_meta;
        mode_meta <= (port_mode == pcm_pkg::MODE_BACKPLANE);
        mode_link <= mode_meta;
    end

    // ------------------------------------------------------------
    // Transmit sample hand-over, link side
    // ------------------------------------------------------------
    always_ff @(posedge link.bit_clk) begin
        if (!lrstn) begin
            req_meta <= 1'h0;
            req_link <= 1'h0;
            req_seen <= 1'h0;
            tx_next  <= pcm_pkg::QUIET_CODE;
        end else begin
            req_meta <= tx_req;
            req_link <= req_meta;
            if (req_new) begin
                tx_next  <= tx_hold;       // Held steady until acknowledged
                req_seen <= req_link;
            end
        end
    end

    // ------------------------------------------------------------
    // Slot timing: strobe or frame pulse edge opens the slot
    // ------------------------------------------------------------
    always_ff @(posedge link.bit_clk) begin
        if (!lrstn) begin
            strobe_prev <= 1'h0;
            slot_pos    <= pcm_pkg::POS_MAX;
        end else begin
            strobe_prev <= link.slot_strobe_frame;   // see [R3]
            if (strobe_rise) begin
                slot_pos <= 6'h00;                   // see [R2]
            end else if (slot_pos != pcm_pkg::POS_MAX) begin
                slot_pos <= slot_pos + 6'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Cascade output: delayed strobe or delayed frame pulse
    // ------------------------------------------------------------
    always_ff @(posedge link.bit_clk) begin
        if (!lrstn) begin
            dly_cnt <= 4'h0;
        end else if (dly_load_strb) begin
            dly_cnt <= pcm_pkg::STROBE_WIDTH;        // see [R4]
        end else if (dly_load_fp) begin
            dly_cnt <= pcm_pkg::FRAME_PULSE_WIDTH;   // see [R5]
        end else if (dly_cnt != 4'h0) begin
            dly_cnt <= dly_cnt - 4'h1;
        end
    end

    // Variant without the cascade pin keeps it low
    assign link.delayed_strobe_frame = HAS_DELAYED_OUT && (dly_cnt != 4'h0);

    // ------------------------------------------------------------
    // Serial engine for the single shared slot
    // ------------------------------------------------------------
    slot_shifter u_shifter (
        .link_clk_in   (link.bit_clk),
        .rstn_in       (lrstn),
        .start_in      (strobe_rise),        // see [R2]
        .tx_word_in    (tx_next),
        .data_in       (link.host_data),     // see [R1]
        .data_out      (link.dev_data),      // see [R10]
        .data_oe_out   (link.dev_data_oe),   // see [R12]
        .rx_word_out   (rx_word_link),
        .rx_toggle_out (rx_toggle_link)
    );

endmodule : pcm_device_end

// ==== core/pcm_host_end.sv ====
`timescale 1ns/1ns
module pcm_host_end (
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    pcm_link_if.host        link,
    input  wire logic [7:0] tx_data_in,
    input  wire logic       tx_valid_in,
    output logic            tx_ready_out,
    output logic [7:0]      rx_data_out,
    output logic            rx_valid_out,
    input  wire logic       mode_backplane_in,
    output logic            cascade_seen_out
);
    logic [4:0] div_cnt;
    logic       bit_clk;
    logic [7:0] bit_pos;
    logic       strobe;
    logic       host_data;
    logic [7:0] pend;
    logic       pend_full;
    logic [7:0] slot_word;
    logic [7:0] rx_shift;
    logic [7:0] rx_data;
    logic       rx_valid;
    logic       line_meta;
    logic       line_sync;
    logic       casc_meta;
    logic       casc_sync;

    // ------------------------------------------------------------
    // Decodes
    // ------------------------------------------------------------
    wire half_done = (div_cnt == pcm_pkg::HALF_DIV_LAST);
    wire rise_evt  = half_done && !bit_clk;
    wire fall_evt  = half_done && bit_clk;
    wire in_slot   = (bit_pos < pcm_pkg::SLOT_END);
    wire last_slot = (bit_pos[2:0] == pcm_pkg::SLOT_LAST) && in_slot;
    wire [7:0] next_pos  = (bit_pos == pcm_pkg::FRAME_LAST) ? 8'h00 : bit_pos + 8'h01;
    wire       next_strb = mode_backplane_in ? (next_pos == 8'h00) : (next_pos < pcm_pkg::SLOT_END);  // see [R3] [R8]
    wire [2:0] tx_index  = pcm_pkg::SLOT_LAST - bit_pos[2:0];
    wire       frame_load = fall_evt && (next_pos == 8'h00);

    // ------------------------------------------------------------
    // Bit clock divider, strobe on falling edges
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            div_cnt <= 5'h00;
            bit_clk <= 1'h0;
            bit_pos <= pcm_pkg::FRAME_LAST;
            strobe  <= 1'h0;
        end else begin
            div_cnt <= half_done ? 5'h00 : div_cnt + 5'h01;
            if (half_done) begin
                bit_clk <= !bit_clk;      // see [R6] [R7]
            end
            if (fall_evt) begin
                bit_pos <= next_pos;
                strobe  <= next_strb;     // see [R3]
            end
        end
    end

    // ------------------------------------------------------------
    // Transmit: pending word enters the slot at frame start
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            pend      <= pcm_pkg::QUIET_CODE;
            pend_full <= 1'h0;
            slot_word <= pcm_pkg::QUIET_CODE;
            host_data <= 1'h1;
        end else begin
            if (frame_load) begin
                slot_word <= pend_full ? pend : pcm_pkg::QUIET_CODE;
                pend_full <= 1'h0;
            end else if (tx_valid_in && !pend_full) begin
                pend      <= tx_data_in;
                pend_full <= 1'h1;
            end
            if (rise_evt) begin
                host_data <= in_slot ? slot_word[tx_index] : 1'h1;
            end
        end
    end

    // Ready while the pending word is free and not being moved into the slot
    assign tx_ready_out = !pend_full && !frame_load;

    // ------------------------------------------------------------
    // Receive: line sampled at falling edges inside the slot
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            line_meta <= 1'h1;
            line_sync <= 1'h1;
            casc_meta <= 1'h0;
            casc_sync <= 1'h0;
            rx_shift  <= 8'h00;
            rx_data   <= 8'h00;
            rx_valid  <= 1'h0;
        end else begin
            line_meta <= link.line_level;
            line_sync <= line_meta;
            casc_meta <= link.delayed_strobe_frame;
            casc_sync <= casc_meta;
            rx_valid  <= fall_evt && last_slot;
            if (fall_evt && in_slot) begin
                rx_shift <= {rx_shift[6:0], line_sync};
            end
            if (fall_evt && last_slot) begin
                rx_data <= {rx_shift[6:0], line_sync};
            end
        end
    end

    // Pins and user outputs
    assign link.bit_clk           = bit_clk;
    assign link.slot_strobe_frame = strobe;
    assign link.host_data         = host_data;
    assign rx_data_out            = rx_data;
    assign rx_valid_out           = rx_valid;
    assign cascade_seen_out       = casc_sync;

endmodule : pcm_host_end

// ==== test/pcm_link_checker.sv ====
`timescale 1ns/1ns
module pcm_link_checker (
    input  wire logic bit_clk,
    input  wire logic rstn_in,
    input  wire logic slot_strobe_frame,
    input  wire logic dev_data_oe,
    input  wire logic delayed_strobe_frame
);

    // ------------------------------------------------------------
    // Arming after the device's reset resync
    // ------------------------------------------------------------
    logic [2:0] arm_q = 3'h0;

    // Shift the reset through three link clock edges before checking
    always_ff @(posedge bit_clk) begin
        arm_q <= {arm_q[1:0], rstn_in};
    end

    default clocking link_cb @(posedge bit_clk);
    endclocking
    default disable iff (!arm_q[2]);

    // ------------------------------------------------------------
    // Slot timing of the device's data output
    // ------------------------------------------------------------
    slot_open_a: assert property ($rose(slot_strobe_frame) |=> dev_data_oe [*8] ##1 !dev_data_oe)
        else $error("slot enable not high for exactly eight bits");
    oe_idle_a: assert property (!dev_data_oe && !$rose(slot_strobe_frame) |=> !dev_data_oe)
        else $error("data output enabled without a slot opening");
    slot_gap_a: assert property ($fell(dev_data_oe) |-> !dev_data_oe [*8])
        else $error("second slot follows straight after a slot");
    oe_cause_a: assert property ($rose(dev_data_oe) |-> $past(slot_strobe_frame))
        else $error("data output enabled without the strobe");
    oe_edge_a: assert property (@(negedge bit_clk) $rose(dev_data_oe) |-> slot_strobe_frame)
        else $error("data output enable not launched on a rising edge");

    // ------------------------------------------------------------
    // Cascade output
    // ------------------------------------------------------------
    cascade_strobe_a: assert property ($fell(slot_strobe_frame) && $past(slot_strobe_frame, 2)
        |=> delayed_strobe_frame [*8] ##1 !delayed_strobe_frame)
        else $error("delayed strobe not eight bits after strobe end");
    cascade_frame_a: assert property ($rose(slot_strobe_frame) ##1 !slot_strobe_frame
        |-> ##32 delayed_strobe_frame ##1 !delayed_strobe_frame)
        else $error("delayed frame pulse not four slots late");
    cascade_excl_a: assert property (delayed_strobe_frame |-> !slot_strobe_frame)
        else $error("delayed strobe overlaps the incoming strobe");

    // Main scenarios reached
    strobe_seen_c: cover property ($rose(slot_strobe_frame));
    strobed_cascade_c: cover property ($fell(slot_strobe_frame) && $past(slot_strobe_frame, 2));
    frame_cascade_c: cover property ($rose(slot_strobe_frame) ##1 !slot_strobe_frame);

endmodule : pcm_link_checker

// ==== test/tb.sv ====
`timescale 1ns/1ns
module tb;

    // ------------------------------------------------------------
    // Stimulus and observation signals
    // ------------------------------------------------------------
    logic       clk_in;
    logic       rstn;
    logic       dev_rstn;
    logic [7:0] dev_tx_data;
    logic       dev_tx_valid;
    logic       dev_tx_ready;
    logic [7:0] dev_rx_data;
    logic       dev_rx_valid;
    logic       cfg_load;
    logic       cfg_backplane;
    logic       cfg_alaw;
    logic       mode_bp;
    logic       law_alaw;
    logic [7:0] host_tx_data;
    logic       host_tx_valid;
    logic       host_tx_ready;
    logic [7:0] host_rx_data;
    logic       host_rx_valid;
    logic       mode_backplane;
    logic       host_casc;
    int         fail_count = 0;
    int         checks_done = 0;
    int         host_rx_count = 0;
    int         dev_rx_count = 0;

    pcm_link_if pcm_link_if_inst ();

    pcm_device_end pcm_device_end_inst (
        .clk_in(clk_in), .rstn_in(dev_rstn), .link(pcm_link_if_inst),
        .tx_data_in(dev_tx_data), .tx_valid_in(dev_tx_valid), .tx_ready_out(dev_tx_ready),
        .rx_data_out(dev_rx_data), .rx_valid_out(dev_rx_valid), .cfg_load_in(cfg_load),
        .cfg_backplane_in(cfg_backplane), .cfg_alaw_in(cfg_alaw),
        .mode_backplane_out(mode_bp), .law_alaw_out(law_alaw));

    pcm_host_end pcm_host_end_inst (
        .clk_in(clk_in), .rstn_in(rstn), .link(pcm_link_if_inst),
        .tx_data_in(host_tx_data), .tx_valid_in(host_tx_valid), .tx_ready_out(host_tx_ready),
        .rx_data_out(host_rx_data), .rx_valid_out(host_rx_valid),
        .mode_backplane_in(mode_backplane), .cascade_seen_out(host_casc));

    pcm_link_checker pcm_link_checker_inst (
        .bit_clk(pcm_link_if_inst.bit_clk), .rstn_in(dev_rstn),
        .slot_strobe_frame(pcm_link_if_inst.slot_strobe_frame),
        .dev_data_oe(pcm_link_if_inst.dev_data_oe),
        .delayed_strobe_frame(pcm_link_if_inst.delayed_strobe_frame));

    // ------------------------------------------------------------
    // Clock, slot counter and watchdog
    // ------------------------------------------------------------
    initial begin
        clk_in = 1'h0;
        forever #4 clk_in = ~clk_in;
    end

    // Count received slots at both ends
    always @(posedge clk_in) begin
        if (host_rx_valid === 1'h1) host_rx_count <= host_rx_count + 1;
        if (dev_rx_valid === 1'h1) dev_rx_count <= dev_rx_count + 1;
    end

    // Six frames of 256 bits at 60 clocks a bit, with margin
    initial begin
        repeat (95000) @(posedge clk_in);
        fail_count++;
        $display("watchdog expired at %0t", $time);
        close_out();
    end

    // ------------------------------------------------------------
    // Expectations, comparisons and transfers
    // ------------------------------------------------------------
    function automatic logic [7:0] exp_word(input logic [7:0] sent, input bit fresh);
        return fresh ? sent : pcm_pkg::QUIET_CODE;
    endfunction : exp_word

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check_byte

    task automatic check_flag(input logic got, input logic exp);
        check_byte({7'h00, got}, {7'h00, exp});
    endtask : check_flag

    task automatic wait_slot();
        int start;
        int d_start;
        int n;
        start = host_rx_count;
        d_start = dev_rx_count;
        n = 0;
        while (host_rx_count == start && n < 20000) begin
            @(posedge clk_in);
            n++;
        end
        check_flag(1'(n < 20000), 1'h1);
        repeat (12) @(posedge clk_in);
        check_byte(8'(dev_rx_count - d_start), 8'h01);
    endtask : wait_slot

    // Width of the next cascade pulse, rounded to bit periods
    task automatic wait_casc(input logic [7:0] bits);
        int n;
        n = 0;
        while (host_casc !== 1'h1 && n < 4000) @(posedge clk_in) n++;
        n = 0;
        while (host_casc === 1'h1 && n < 4000) @(posedge clk_in) n++;
        check_byte(8'((n + pcm_pkg::HALF_DIV_LAST + 1) / (2 * (pcm_pkg::HALF_DIV_LAST + 1))), bits);
    endtask : wait_casc

    task automatic send_pair(input logic [7:0] d_word, input logic [7:0] h_word);
        logic d_take;
        logic h_take;
        int   n;
        n = 0;
        @(posedge clk_in);
        dev_tx_data <= d_word;
        dev_tx_valid <= 1'h1;
        host_tx_data <= h_word;
        host_tx_valid <= 1'h1;
        do begin
            @(negedge clk_in);
            d_take = (dev_tx_ready === 1'h1) && dev_tx_valid;
            h_take = (host_tx_ready === 1'h1) && host_tx_valid;
            @(posedge clk_in);
            if (d_take) dev_tx_valid <= 1'h0;
            if (h_take) host_tx_valid <= 1'h0;
            n++;
        end while ((dev_tx_valid || host_tx_valid) && n < 200);
        check_flag(1'(dev_tx_valid || host_tx_valid), 1'h0);
    endtask : send_pair

    task automatic run_pair(input logic [7:0] d_word, input logic [7:0] h_word, input string name);
        send_pair(d_word, h_word);
        wait_slot();
        check_byte(host_rx_data, exp_word(d_word, 1'h1));
        check_byte(dev_rx_data, exp_word(h_word, 1'h1));
        wait_casc(mode_backplane ? 8'h01 : 8'h08);
        $display("test %s done", name);
    endtask : run_pair

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic alaw;
        rstn = 1'h0;
        dev_rstn = 1'h0;
        dev_tx_data = 8'h00;
        dev_tx_valid = 1'h0;
        cfg_load = 1'h0;
        cfg_backplane = 1'h0;
        cfg_alaw = 1'h0;
        host_tx_data = 8'h00;
        host_tx_valid = 1'h0;
        mode_backplane = 1'h0;
        void'($urandom(12592));
        repeat (5) @(posedge clk_in);
        rstn <= 1'h1;
        repeat (700) @(posedge clk_in);
        dev_rstn <= 1'h1;
        @(negedge clk_in);
        check_flag(mode_bp, 1'h0);
        check_flag(law_alaw, 1'h0);
        wait_slot();
        check_byte(host_rx_data, exp_word(8'h00, 1'h0));
        $display("test reset_defaults done");
        run_pair(8'h80, 8'h01, "strobed_corner");
        run_pair(8'($urandom), 8'($urandom), "strobed_random");
        alaw = 1'($urandom);
        @(posedge clk_in);
        cfg_load <= 1'h1;
        cfg_backplane <= 1'h1;
        cfg_alaw <= alaw;
        mode_backplane <= 1'h1;
        @(posedge clk_in);
        cfg_load <= 1'h0;
        @(negedge clk_in);
        check_flag(mode_bp, 1'h1);
        check_flag(law_alaw, alaw);
        run_pair(8'($urandom), 8'h7E, "backplane_corner");
        run_pair(8'($urandom), 8'($urandom), "backplane_random");
        close_out();
    end

endmodule : tb
